/* design/audio_port_config_regs.sv */
// Serial audio port configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "audio_port_map.svh"
module audio_port_config_regs (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    // Register access
    input  wire audio_port_pkg::reg_req_s req,
    output logic [7:0]                   rdata,
    output logic                         rvalid,
    // General pins
    input  wire logic                    general_pin_one,
    input  wire logic                    general_pin_two,
    input  wire logic                    general_input_pin,
    input  wire logic                    data_in_pin,
    // Events from the port logic
    input  wire logic                    bus_error,
    input  wire logic                    bus_error_cleared,
    // Decoded controls
    output audio_port_pkg::pin_ctrl_s    pin_ctrl,
    output audio_port_pkg::port_ctrl_s   port_ctrl,
    output audio_port_pkg::fmt_ctrl_s    fmt_ctrl,
    output logic                         mic_bias_on,
    output logic                         aux_conv_start,
    output logic                         daisy_in,
    output logic                         port_halted
);
    import audio_port_pkg::*;

    // Assertions below share one clock and one reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic [7:0] pin_func_reg;
    logic [7:0] port_en_reg;
    logic [7:0] lane_reg;
    logic [7:0] fmt_reg;
    logic       halted_reg;
    logic       bias_lvl;
    logic       conv_lvl;
    logic       conv_prev_reg;
    logic       daisy_lvl;
    pin_src_e   bias_sel;
    pin_src_e   conv_sel;

    // Reserved codes fall back to a safe off state
    function automatic lane_e lane_dec(input logic [1:0] c);
        lane_dec = (c == 2'h3) ? lane_none : lane_e'(c);
    endfunction

    function automatic logic [5:0] wlen_dec(input logic [1:0] c);
        unique case (c)
            2'h0: wlen_dec = 6'h10;
            2'h1: wlen_dec = 6'h14;
            2'h2: wlen_dec = 6'h18;
            2'h3: wlen_dec = 6'h20;
        endcase
    endfunction

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_func_reg <= `PIN_FUNC_RST;
        end else if (req.wr_en && req.addr == `PIN_FUNC_OFS) begin
            pin_func_reg <= req.wdata & `PIN_FUNC_WMASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_en_reg <= `PORT_EN_DAISY_RST;
        end else if (req.wr_en && req.addr == `PORT_EN_DAISY_OFS) begin
            port_en_reg <= req.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lane_reg <= `LANE_CFG_RST;
        end else if (req.wr_en && req.addr == `LANE_CFG_OFS) begin
            // Bits 2-0 are masked on write and held at reset value
            lane_reg <= req.wdata & `LANE_CFG_WMASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fmt_reg <= `PRI_FORMAT_RST;
        end else if (req.wr_en && req.addr == `PRI_FORMAT_OFS) begin
            fmt_reg <= req.wdata;
        end
    end

    // Read path, unmapped offsets read zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd_en;
            unique case (req.addr)
                `PIN_FUNC_OFS:      rdata <= pin_func_reg & `PIN_FUNC_WMASK;
                `PORT_EN_DAISY_OFS: rdata <= port_en_reg;
                `LANE_CFG_OFS:      rdata <= lane_reg & `LANE_CFG_RMASK;
                `PRI_FORMAT_OFS:    rdata <= fmt_reg;
                default:            rdata <= 8'h00;
            endcase
        end
    end

    assign bias_sel = pin_src_e'(pin_func_reg[`FLD_HI_POS +: 2]);
    assign conv_sel = pin_src_e'(pin_func_reg[`FLD_MID_POS +: 2]);

    pin_src_sel u_bias_sel (
        .sel               (bias_sel),
        .general_pin_one   (general_pin_one),
        .general_pin_two   (general_pin_two),
        .general_input_pin (general_input_pin),
        .level             (bias_lvl)
    );

    pin_src_sel u_conv_sel (
        .sel               (conv_sel),
        .general_pin_one   (general_pin_one),
        .general_pin_two   (general_pin_two),
        .general_input_pin (general_input_pin),
        .level             (conv_lvl)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pin_ctrl      <= '0;
            mic_bias_on   <= 1'b0;
            aux_conv_start <= 1'b0;
            conv_prev_reg <= 1'b0;
        end else begin
            pin_ctrl.mic_bias_pin_select       <= bias_sel;
            pin_ctrl.aux_conv_start_pin_select <= conv_sel;
            mic_bias_on    <= bias_lvl;
            // Rising edge starts one conversion, a held pin does not retrigger
            conv_prev_reg  <= conv_lvl;
            aux_conv_start <= conv_lvl & ~conv_prev_reg;
        end
    end

    // Daisy source decode, reserved codes give no input
    always_comb begin
        unique case (port_en_reg[`DAISY_IN_POS +: 3])
            3'h1:    daisy_lvl = general_pin_one;
            3'h2:    daisy_lvl = general_pin_two;
            3'h3:    daisy_lvl = general_input_pin;
            3'h5:    daisy_lvl = data_in_pin;
            default: daisy_lvl = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_ctrl <= '{primary_on: 1'b1, daisy_mode: daisy_off,
                daisy_src: daisy_src_off, output_lane_alloc: lane_split,
                input_lane_alloc: lane_split, default: 1'b0};
            daisy_in  <= 1'b0;
        end else begin
            // Daisy on one port takes the other port away
            port_ctrl.primary_on <= ~port_en_reg[`PRI_OFF_BIT] && ~halted_reg
                && port_en_reg[`DAISY_EN_POS +: 2] != 2'h2;
            port_ctrl.secondary_on <= ~port_en_reg[`SEC_OFF_BIT]
                && port_en_reg[`DAISY_EN_POS +: 2] != 2'h1;
            port_ctrl.secondary_follows_primary <= port_en_reg[`GANG_BIT];
            unique case (port_en_reg[`DAISY_EN_POS +: 2])
                2'h1:    port_ctrl.daisy_mode <= daisy_primary;
                2'h2:    port_ctrl.daisy_mode <= daisy_secondary;
                default: port_ctrl.daisy_mode <= daisy_off;
            endcase
            unique case (port_en_reg[`DAISY_IN_POS +: 3])
                3'h1:    port_ctrl.daisy_src <= daisy_src_pin_one;
                3'h2:    port_ctrl.daisy_src <= daisy_src_pin_two;
                3'h3:    port_ctrl.daisy_src <= daisy_src_input_pin;
                3'h5:    port_ctrl.daisy_src <= daisy_src_data_in;
                default: port_ctrl.daisy_src <= daisy_src_off;
            endcase
            port_ctrl.daisy_input_dir <= lane_reg[`DAISY_DIR_BIT];
            port_ctrl.output_lane_alloc <=
                lane_dec(lane_reg[`FLD_HI_POS +: 2]);
            port_ctrl.input_lane_alloc <=
                lane_dec(lane_reg[`FLD_MID_POS +: 2]);
            daisy_in <= daisy_lvl;
        end
    end

    // Error latch; a new error in the clear cycle wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            halted_reg <= 1'b0;
        end else if (bus_error && ~fmt_reg[`ERR_OFF_BIT]) begin
            halted_reg <= 1'b1;
        end else if (req.wr_en && req.addr == `PRI_FORMAT_OFS) begin
            halted_reg <= 1'b0;
        end else if (bus_error_cleared && ~fmt_reg[`NO_RESUME_BIT]) begin
            halted_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Decoded view matches the register reset value at once
            fmt_ctrl    <= '{primary_frame_format: fmt_tdm,
                primary_word_length: 6'h20, bus_error_detect_on: 1'b1,
                bus_error_auto_resume: 1'b1, default: 1'b0};
            port_halted <= 1'b0;
        end else begin
            fmt_ctrl.primary_frame_format <=
                frame_fmt_e'(fmt_reg[`FLD_HI_POS +: 2]);
            fmt_ctrl.primary_word_length <=
                wlen_dec(fmt_reg[`FLD_MID_POS +: 2]);
            fmt_ctrl.primary_frame_sync_invert <= fmt_reg[`FS_INV_BIT];
            fmt_ctrl.primary_bit_clock_invert <= fmt_reg[`BCLK_INV_BIT];
            // Ganged secondary gets the polarity only through the gang path
            fmt_ctrl.sec_frame_sync_invert <= port_en_reg[`GANG_BIT]
                & fmt_reg[`FS_INV_BIT];
            fmt_ctrl.sec_bit_clock_invert <= port_en_reg[`GANG_BIT]
                & fmt_reg[`BCLK_INV_BIT];
            fmt_ctrl.bus_error_detect_on <= ~fmt_reg[`ERR_OFF_BIT];
            fmt_ctrl.bus_error_auto_resume <= ~fmt_reg[`NO_RESUME_BIT];
            port_halted <= halted_reg;
        end
    end

    a_pin_func_zero: assert property (
        req.rd_en && req.addr == `PIN_FUNC_OFS |=> rdata[3:0] == 4'h0)
        else $error("reserved pin bits read nonzero");

    a_pin_low_zero: assert property (
        req.wr_en && req.addr == `PIN_FUNC_OFS |=> pin_func_reg[3:0] == 4'h0)
        else $error("reserved pin bits stored");

    a_bias_none: assert property (
        pin_func_reg[7:6] == 2'h0 |=> !mic_bias_on)
        else $error("mic bias on with no source");

    a_bias_pin_one: assert property (
        pin_func_reg[7:6] == 2'h1 |=> mic_bias_on == $past(general_pin_one))
        else $error("mic bias does not follow pin one");

    sequence conv_rise;
        !conv_lvl ##1 conv_lvl;
    endsequence
    a_conv_start_edge: assert property (
        conv_rise |=> aux_conv_start)
        else $error("no start pulse on pin rise");

    a_conv_single: assert property (
        aux_conv_start |=> !aux_conv_start)
        else $error("start pulse longer than one cycle");

    a_daisy_kills_sec: assert property (
        port_en_reg[4:3] == 2'h1 |=> !port_ctrl.secondary_on)
        else $error("secondary on during primary daisy");

    a_daisy_kills_pri: assert property (
        port_en_reg[4:3] == 2'h2 |=> !port_ctrl.primary_on)
        else $error("primary on during secondary daisy");

    a_daisy_rsvd_mode: assert property (
        port_en_reg[4:3] == 2'h3 |=> port_ctrl.daisy_mode == daisy_off)
        else $error("reserved daisy mode active");

    a_pri_off_bit: assert property (
        port_en_reg[7] |=> !port_ctrl.primary_on)
        else $error("primary on while disabled");

    a_sec_off_bit: assert property (
        port_en_reg[6] |=> !port_ctrl.secondary_on)
        else $error("secondary on while disabled");

    a_gang_copy: assert property (
        port_en_reg[5] |=> port_ctrl.secondary_follows_primary
            && fmt_ctrl.sec_frame_sync_invert == $past(fmt_reg[3])
            && fmt_ctrl.sec_bit_clock_invert == $past(fmt_reg[2]))
        else $error("ganged secondary settings differ");

    a_sec_pol_alone: assert property (
        !port_en_reg[5] |=> !fmt_ctrl.sec_frame_sync_invert
            && !fmt_ctrl.sec_bit_clock_invert)
        else $error("primary polarity leaked to secondary");

    a_daisy_reserved: assert property (
        port_en_reg[2:0] == 3'h4 || port_en_reg[2:0] > 3'h5
            |=> !daisy_in && port_ctrl.daisy_src == daisy_src_off)
        else $error("reserved daisy source active");

    a_daisy_data_in: assert property (
        port_en_reg[2:0] == 3'h5 |=> daisy_in == $past(data_in_pin))
        else $error("daisy input not from data pin");

    a_lane_reserved: assert property (
        lane_reg[7:6] == 2'h3 |=> port_ctrl.output_lane_alloc == lane_none)
        else $error("reserved lane code active");

    a_in_lane_rsvd: assert property (
        lane_reg[5:4] == 2'h3 |=> port_ctrl.input_lane_alloc == lane_none)
        else $error("reserved input lane code active");

    a_lane_low_zero: assert property (
        req.wr_en && req.addr == `LANE_CFG_OFS |=> lane_reg[2:0] == 3'h0)
        else $error("reserved lane bits stored");

    a_fmt_reserved: assert property (
        fmt_reg[7:6] == 2'h3 |=> fmt_ctrl.primary_frame_format == fmt_off)
        else $error("reserved frame format active");

    a_reset_values: assert property (
        $past(rst) |-> port_en_reg == `PORT_EN_DAISY_RST
            && fmt_reg == `PRI_FORMAT_RST)
        else $error("reset value wrong");

    a_wlen_sixteen: assert property (
        fmt_reg[5:4] == 2'h0 ##1 fmt_reg[5:4] == 2'h0
        |-> fmt_ctrl.primary_word_length == 6'h10)
        else $error("word length decode wrong");

    a_halt_on_err: assert property (
        bus_error && !fmt_reg[1] |=> halted_reg ##1 port_halted)
        else $error("bus error not latched");

    a_detect_off: assert property (
        bus_error && fmt_reg[1] && !halted_reg |=> !halted_reg)
        else $error("error latched with detection off");

    sequence err_then_clear;
        halted_reg && bus_error_cleared && !bus_error && !req.wr_en;
    endsequence
    a_no_resume: assert property (
        err_then_clear and fmt_reg[0] |=> halted_reg)
        else $error("resumed with auto resume off");

    a_auto_resume: assert property (
        err_then_clear and !fmt_reg[0] |=> !halted_reg)
        else $error("no auto resume");
endmodule
`default_nettype wire

/* design/audio_port_map.svh */
// Register offsets, field positions and reset values for the port config bank
`ifndef AUDIO_PORT_MAP_SVH
`define AUDIO_PORT_MAP_SVH
`define PIN_FUNC_OFS        8'h15
`define PORT_EN_DAISY_OFS   8'h18
`define LANE_CFG_OFS        8'h19
`define PRI_FORMAT_OFS      8'h1a
`define PIN_FUNC_RST        8'h00
`define PORT_EN_DAISY_RST   8'h40
`define LANE_CFG_RST        8'h00
`define PRI_FORMAT_RST      8'h30
`define PIN_FUNC_WMASK      8'hf0
`define LANE_CFG_WMASK      8'hf8
`define LANE_CFG_RMASK      8'hfe
`define FLD_HI_POS          6
`define FLD_MID_POS         4
`define DAISY_EN_POS        3
`define DAISY_IN_POS        0
`define DAISY_DIR_BIT       3
`define PRI_OFF_BIT         7
`define SEC_OFF_BIT         6
`define GANG_BIT            5
`define FS_INV_BIT          3
`define BCLK_INV_BIT        2
`define ERR_OFF_BIT         1
`define NO_RESUME_BIT       0
`endif

/* design/audio_port_pkg.sv */
// Types shared by the port config bank
package audio_port_pkg;
    typedef enum logic [1:0] {
        src_none,
        src_pin_one,
        src_pin_two,
        src_input_pin
    } pin_src_e;
    typedef enum logic [2:0] {
        daisy_src_off,
        daisy_src_pin_one,
        daisy_src_pin_two,
        daisy_src_input_pin,
        daisy_src_data_in
    } daisy_src_e;
    typedef enum logic [1:0] {
        fmt_tdm,
        fmt_i2s,
        fmt_left_justified,
        fmt_off
    } frame_fmt_e;
    typedef enum logic [1:0] {
        lane_split,
        lane_two_primary,
        lane_two_secondary,
        lane_none
    } lane_e;
    typedef enum logic [1:0] {
        daisy_off,
        daisy_primary,
        daisy_secondary
    } daisy_mode_e;
    typedef struct packed {
        logic        wr_en;
        logic        rd_en;
        logic [7:0]  addr;
        logic [7:0]  wdata;
    } reg_req_s;
    typedef struct packed {
        pin_src_e    mic_bias_pin_select;
        pin_src_e    aux_conv_start_pin_select;
    } pin_ctrl_s;
    typedef struct packed {
        logic        primary_on;
        logic        secondary_on;
        logic        secondary_follows_primary;
        daisy_mode_e daisy_mode;
        daisy_src_e  daisy_src;
        logic        daisy_input_dir;
        lane_e       output_lane_alloc;
        lane_e       input_lane_alloc;
    } port_ctrl_s;
    typedef struct packed {
        frame_fmt_e  primary_frame_format;
        logic [5:0]  primary_word_length;
        logic        primary_frame_sync_invert;
        logic        primary_bit_clock_invert;
        logic        bus_error_detect_on;
        logic        bus_error_auto_resume;
        logic        sec_frame_sync_invert;
        logic        sec_bit_clock_invert;
    } fmt_ctrl_s;
endpackage

/* design/pin_src_sel.sv */
// Picks one of the three general pins by a two-bit source code
`timescale 1ns/1ns
`default_nettype none
module pin_src_sel (
    // Selection
    input  wire audio_port_pkg::pin_src_e sel,
    // Pins
    input  wire logic                     general_pin_one,
    input  wire logic                     general_pin_two,
    input  wire logic                     general_input_pin,
    // Result
    output logic                          level
);
    import audio_port_pkg::*;
    always_comb begin
        unique case (sel)
            src_none:      level = 1'b0;
            src_pin_one:   level = general_pin_one;
            src_pin_two:   level = general_pin_two;
            src_input_pin: level = general_input_pin;
        endcase
    end
endmodule
`default_nettype wire

/* verification/audio_port_config_regs_bench.sv */
// Self-checking bench for the port config register bank
`timescale 1ns/1ns
`default_nettype none
module audio_port_config_regs_bench;
    import audio_port_pkg::*;
    logic       ref_clk = 1'b0;
    logic       rst = 1'b1;
    reg_req_s   req = '0;
    logic [7:0] rdata;
    logic       rvalid;
    logic [3:0] pins = 4'h0;
    logic       bus_error = 1'b0;
    logic       bus_error_cleared = 1'b0;
    pin_ctrl_s  pin_ctrl;
    port_ctrl_s port_ctrl;
    fmt_ctrl_s  fmt_ctrl;
    logic       mic_bias_on, aux_conv_start, daisy_in, port_halted;
    int         miscompares = 0;
    int         n_tests = 0;
    int         cnt;
    logic [7:0] seed = 8'h04;
    logic [7:0] s15, s18, s19, s1a, d, a;

    always #25 ref_clk = ~ref_clk;

    audio_port_config_regs dut_u (
        .ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .general_pin_one(pins[0]),
        .general_pin_two(pins[1]), .general_input_pin(pins[2]),
        .data_in_pin(pins[3]), .bus_error(bus_error),
        .bus_error_cleared(bus_error_cleared), .pin_ctrl(pin_ctrl),
        .port_ctrl(port_ctrl), .fmt_ctrl(fmt_ctrl),
        .mic_bias_on(mic_bias_on), .aux_conv_start(aux_conv_start),
        .daisy_in(daisy_in), .port_halted(port_halted)
    );

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic logic sel_pin(input logic [1:0] c,
                                     input logic [3:0] p);
        return (c == 2'h0) ? 1'b0 : p[c - 2'h1];
    endfunction

    function automatic logic daisy_exp(input logic [2:0] c,
                                       input logic [3:0] p);
        if (c == 3'h5) return p[3];
        // Reserved source codes must stay inert
        return (c > 3'h3) ? 1'b0 : sel_pin(c[1:0], p);
    endfunction

    function automatic port_ctrl_s exp_port(input logic [7:0] r0, r1);
        port_ctrl_s e;
        e.daisy_mode = (r0[4:3] == 2'h3) ? daisy_off : daisy_mode_e'(r0[4:3]);
        e.primary_on = !r0[7] && e.daisy_mode != daisy_secondary;
        e.secondary_on = !r0[6] && e.daisy_mode != daisy_primary;
        e.secondary_follows_primary = r0[5];
        e.daisy_src = (r0[2:0] == 3'h5) ? daisy_src_data_in :
                      (r0[2:0] > 3'h3) ? daisy_src_off : daisy_src_e'(r0[2:0]);
        e.daisy_input_dir = r1[3];
        e.output_lane_alloc = lane_e'(r1[7:6]);
        e.input_lane_alloc = lane_e'(r1[5:4]);
        return e;
    endfunction

    function automatic fmt_ctrl_s exp_fmt(input logic [7:0] f, g);
        fmt_ctrl_s e;
        e.primary_frame_format = frame_fmt_e'(f[7:6]);
        case (f[5:4])
            2'h0: e.primary_word_length = 6'h10;
            2'h1: e.primary_word_length = 6'h14;
            2'h2: e.primary_word_length = 6'h18;
            default: e.primary_word_length = 6'h20;
        endcase
        e.primary_frame_sync_invert = f[3];
        e.primary_bit_clock_invert = f[2];
        e.bus_error_detect_on = !f[1];
        e.bus_error_auto_resume = !f[0];
        e.sec_frame_sync_invert = g[5] & f[3];
        e.sec_bit_clock_invert = g[5] & f[2];
        return e;
    endfunction

    task automatic chk(input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Shadows keep only the bits the bank is expected to hold
    task automatic wr(input logic [7:0] ad, dt);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, ad, dt};
        @(posedge ref_clk);
        req <= '0;
        case (ad)
            8'h15: s15 = dt & 8'hf0;
            8'h18: s18 = dt;
            8'h19: s19 = dt & 8'hf8;
            8'h1a: s1a = dt;
            default: ;
        endcase
    endtask

    task automatic rd(input logic [7:0] ad, exp);
        @(posedge ref_clk);
        req <= '{1'b0, 1'b1, ad, 8'h00};
        @(posedge ref_clk);
        req <= '0;
        #1;
        chk(rvalid, 1'b1);
        chk(rdata, exp);
    endtask

    task automatic check_all;
        wait_cyc(2);
        chk(pin_ctrl, s15[7:4]);
        chk(port_ctrl, exp_port(s18, s19));
        chk(fmt_ctrl, exp_fmt(s1a, s18));
        @(posedge ref_clk);
        pins <= seed[3:0];
        seed = lfsr(seed);
        wait_cyc(3);
        chk(daisy_in, daisy_exp(s18[2:0], pins));
    endtask

    task automatic reset_check;
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        {s15, s18, s19, s1a} = 32'h0040_0030;
        rd(8'h15, 8'h00);
        rd(8'h18, 8'h40);
        rd(8'h19, 8'h00);
        rd(8'h1a, 8'h30);
        rd(8'h16, 8'h00);
        check_all();
    endtask

    task automatic ev(input logic e, c, ex);
        port_ctrl_s pe;
        @(posedge ref_clk);
        bus_error <= e;
        bus_error_cleared <= c;
        @(posedge ref_clk);
        bus_error <= 1'b0;
        bus_error_cleared <= 1'b0;
        wait_cyc(4);
        pe = exp_port(s18, s19);
        chk(port_halted, ex);
        chk(port_ctrl.primary_on, pe.primary_on & ~ex);
    endtask

    initial begin
        #4000000;
        miscompares++;
        give_verdict();
    end

    initial begin
        @(posedge ref_clk);
        reset_check();
        wr(8'h15, 8'hff);
        rd(8'h15, 8'hf0);
        wr(8'h16, 8'hff);
        rd(8'h16, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(8'h15, {c[1:0], c[1:0], 4'h0});
            @(posedge ref_clk);
            pins <= 4'h0;
            wait_cyc(3);
            cnt = 0;
            @(posedge ref_clk);
            pins <= 4'h7;
            repeat (6) begin
                @(posedge ref_clk);
                #1;
                cnt += (aux_conv_start === 1'b1);
            end
            chk(cnt, c != 0);
            repeat (4) begin
                @(posedge ref_clk);
                pins <= seed[3:0];
                seed = lfsr(seed);
                wait_cyc(3);
                chk(mic_bias_on, sel_pin(c[1:0], pins));
            end
        end
        // Every daisy, lane and format code, reserved ones included
        for (int k = 0; k < 8; k++) begin
            wr(8'h18, {~k[2:0], k[1:0], k[2:0]});
            wr(8'h19, {k[1:0], ~k[1:0], k[0], 3'h0});
            wr(8'h1a, {k[1:0], ~k[1:0], k[2:0], 1'b0});
            check_all();
        end
        repeat (30) begin
            seed = lfsr(seed);
            d = seed;
            seed = lfsr(seed);
            a = (seed[1:0] == 2'h0) ? 8'h15 : 8'h17 + seed[1:0];
            if (a == 8'h15) d = d & 8'hf0;
            if (a == 8'h19) d = d & 8'hf8;
            wr(a, d);
            rd(a, d);
            check_all();
        end
        wr(8'h1a, 8'h00);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b1, 1'b0);
        wr(8'h1a, 8'h01);
        ev(1'b1, 1'b0, 1'b1);
        ev(1'b0, 1'b1, 1'b1);
        wr(8'h1a, 8'h01);
        wait_cyc(3);
        chk(port_halted, 1'b0);
        // Error and a format write in one cycle: the error wins
        @(posedge ref_clk);
        bus_error <= 1'b1;
        req <= '{1'b1, 1'b0, 8'h1a, 8'h01};
        @(posedge ref_clk);
        bus_error <= 1'b0;
        req <= '0;
        wait_cyc(4);
        chk(port_halted, 1'b1);
        wr(8'h1a, 8'h02);
        ev(1'b1, 1'b0, 1'b0);
        @(posedge ref_clk);
        reset_check();
        give_verdict();
    end
endmodule
`default_nettype wire
